// ===== bench/pc_card_area_timing_control_tb.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// self-checking bench with a behavioural register and timing model
// ------------------------------------------------------------
module pc_card_area_timing_control_tb;
    logic        ref_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [1:0]  area_card_mode = 2'b11;
    logic        acc_req = 1'b0;
    logic        acc_area = 1'b0;
    logic        acc_a25 = 1'b0;
    logic        acc_write = 1'b0;
    logic        acc_busy, acc_done, card_wait_n, card_addr_valid;
    logic        card_rd_n, card_we_n, card_io_sel;
    logic [7:0]  stall = 8'h00;
    int          fail_count = 0;
    int          n_tests = 0;
    logic [31:0] rng = 32'h6e4e;
    logic [31:0] cfg_m [2];
    int          wt [16] = '{3, 6, 9, 12, 15, 18, 22, 26,
                             30, 33, 36, 38, 52, 60, 64, 80};

    pcat_area_timing dut (.ref_clk(ref_clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .area_card_mode(area_card_mode), .acc_req(acc_req),
        .acc_area(acc_area), .acc_a25(acc_a25), .acc_write(acc_write),
        .acc_busy(acc_busy), .acc_done(acc_done),
        .card_wait_n(card_wait_n), .card_addr_valid(card_addr_valid),
        .card_rd_n(card_rd_n), .card_we_n(card_we_n),
        .card_io_sel(card_io_sel));
    pcat_card_model card (.ref_clk(ref_clk), .card_rd_n(card_rd_n),
        .card_we_n(card_we_n), .stall_cycles(stall),
        .card_wait_n(card_wait_n));

    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    // xorshift source of random stimulus
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    // one comparison, counted and reported on mismatch
    task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // single-cycle register write; model keeps writable bits only
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        if (a == 8'h00 || a == 8'h04)
            cfg_m[a[2]] = d & 32'h0030_7fcf;
    endtask

    // read, data checked in the cycle after the strobe
    task automatic rd_chk(logic [7:0] a);
        logic [31:0] e;
        e = (a == 8'h00) ? cfg_m[0] : (a == 8'h04) ? cfg_m[1] : 32'h0;
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        cmp("reg_rdata", e, reg_rdata);
    endtask

    // one card access, phase lengths measured at falling edges
    task automatic acc(logic area, logic a25, logic w);
        logic [31:0] c;
        logic        io;
        int          ns, nl, nh, bad, k;
        c = cfg_m[area];
        ns = 0;
        nl = 0;
        nh = 0;
        bad = 0;
        @(posedge ref_clk);
        io = area_card_mode[area] & (a25 ? c[21] : c[20]);
        acc_req <= 1'b1;
        acc_area <= area;
        acc_a25 <= a25;
        acc_write <= w;
        @(posedge ref_clk);
        acc_req <= 1'b0;
        for (k = 0; k < 2000 && acc_done !== 1'b1; k++) begin
            @(negedge ref_clk);
            if (acc_busy === 1'b1) begin
                if (card_rd_n === 1'b1 && card_we_n === 1'b1) begin
                    if (nl == 0) ns++;
                    else nh++;
                end else nl++;
                if (card_io_sel !== io || card_addr_valid !== 1'b1) bad++;
                if ((w ? card_rd_n : card_we_n) !== 1'b1) bad++;
            end
        end
        cmp("acc_done", 1, acc_done);
        cmp("setup_len", 2 * c[14:11] + 1, ns);
        cmp("hold_len", 2 * c[3:0] + 1, nh);
        cmp("io_sel_strobe", 0, bad);
        if (stall == 8'h00 || c[6])
            cmp("strobe_len", 2 * wt[c[10:7]], nl);
        else
            cmp("ext_wait", 1, nl >= stall && nl > 2 * wt[c[10:7]]);
    endtask

    // main sequence
    initial begin
        logic [31:0] d;
        logic [31:0] r;
        cfg_m[0] = 32'h0000_0500;
        cfg_m[1] = 32'h0000_0500;
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd_chk(8'h00);
        rd_chk(8'h04);
        rd_chk(8'h08);
        acc(1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            d = rnd() & 32'h0030_7fcf & ~32'h0000_4000;
            d[10:7] = i[3:0];
            wr({5'h00, r[31], 2'b00}, d);
            rd_chk(8'h00);
            rd_chk(8'h04);
            @(posedge ref_clk);
            area_card_mode <= r[30:29];
            acc(r[31], r[28], r[27]);
        end
        wr(8'h0c, rnd());
        rd_chk(8'h00);
        rd_chk(8'h0c);
        stall <= 8'h0c;
        wr(8'h00, 32'h0000_0000);
        acc(1'b0, 1'b1, 1'b1);
        wr(8'h00, 32'h0000_0040);
        acc(1'b0, 1'b1, 1'b0);
        final_report();
    end

    // watchdog against a hung handshake
    initial begin
        #200_000;
        fail_count++;
        final_report();
    end
endmodule

// ===== bench/pcat_card_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// card stand-in: holds its wait line low for a commanded span
// ------------------------------------------------------------
module pcat_card_model (
    input  wire logic       ref_clk,
    input  wire logic       card_rd_n,
    input  wire logic       card_we_n,
    input  wire logic [7:0] stall_cycles,
    output logic            card_wait_n
);
    logic       strobe_on;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;

    // strobe cycles seen so far, cleared while strobes are idle
    assign strobe_on = !(card_rd_n && card_we_n);
    always_comb begin
        cnt_next = cnt_reg;
        if (!strobe_on)
            cnt_next = 8'h00;
        else if (cnt_reg != 8'hff)
            cnt_next = cnt_reg + 8'h01;
    end
    always_ff @(posedge ref_clk) begin
        cnt_reg <= cnt_next;
    end
    // wait low only inside the stall span; pulled up otherwise
    assign card_wait_n = !(strobe_on && (cnt_reg < stall_cycles));
endmodule

// ===== verilog/pcat_area_timing.sv
`timescale 1ns/1ns
// Summary of operation
// - reserved bits 31..22, 19..15 and 5..4 read zero; software writes zero
// - space attribute bits only matter while the area is in card mode
// - address bit 25 high: upper attribute picks memory or io card
// - address bit 25 low: lower attribute picks memory or io card
// - setup field n gives n plus half bus cycles before strobe
// - wait field codes map to the fixed table of wait cycles
// - wait field resets to 1010, thirty six cycles
// - setup field resets to zero, half a cycle
// - mask bit zero honours external wait, one ignores it
// - hold field n keeps address n plus half cycles after strobe
module pcat_area_timing #(
    parameter int ADDR_W = 8
) (
    input  wire logic              ref_clk,
    input  wire logic              arst_n,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [31:0]            reg_rdata,
    input  wire logic [1:0]        area_card_mode,
    input  wire logic              acc_req,
    input  wire logic              acc_area,
    input  wire logic              acc_a25,
    input  wire logic              acc_write,
    output logic                   acc_busy,
    output logic                   acc_done,
    input  wire logic              card_wait_n,
    output logic                   card_addr_valid,
    output logic                   card_rd_n,
    output logic                   card_we_n,
    output logic                   card_io_sel
);
    // the map needs address bit 2 to tell the two areas apart
    if (ADDR_W < 3) begin : g_addr_w_chk
        $error("ADDR_W too small for the register map");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // wait field to bus cycles
    function automatic logic [7:0] wait_cycles(input logic [3:0] code);
        logic [7:0] r;
        r = 8'h03;
        unique case (code)
            4'h0: r = 8'd3;
            4'h1: r = 8'd6;
            4'h2: r = 8'd9;
            4'h3: r = 8'd12;
            4'h4: r = 8'd15;
            4'h5: r = 8'd18;
            4'h6: r = 8'd22;
            4'h7: r = 8'd26;
            4'h8: r = 8'd30;
            4'h9: r = 8'd33;
            4'ha: r = 8'd36;
            4'hb: r = 8'd38;
            4'hc: r = 8'd52;
            4'hd: r = 8'd60;
            4'he: r = 8'd64;
            4'hf: r = 8'd80;
        endcase
        return r;
    endfunction

    // n plus a half bus cycle, in ref_clk ticks
    function automatic logic [7:0] half_ticks(input logic [3:0] n);
        return {3'h0, n, 1'b0} + pcat_pkg::HALF_TICKS;
    endfunction

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic [31:0] cfg_reg  [2];
    logic [31:0] cfg_next [2];
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        hit5;
    logic        hit6;

    assign hit5 = reg_addr == ADDR_W'(pcat_pkg::AREA5_CFG_OFS);
    assign hit6 = reg_addr == ADDR_W'(pcat_pkg::AREA6_CFG_OFS);

    // writes keep only defined bits; unmapped reads give zero
    always_comb begin
        cfg_next[0] = cfg_reg[0];
        cfg_next[1] = cfg_reg[1];
        rdata_next  = 32'h0000_0000;
        if (reg_wr && hit5) begin
            cfg_next[0] = reg_wdata & pcat_pkg::CFG_WR_MASK;
        end
        if (reg_wr && hit6) begin
            cfg_next[1] = reg_wdata & pcat_pkg::CFG_WR_MASK;
        end
        if (reg_rd && hit5) begin
            rdata_next = cfg_reg[0];
        end else if (reg_rd && hit6) begin
            rdata_next = cfg_reg[1];
        end
    end

    // reset loads wait 1010 and setup 0000
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_reg[0] <= pcat_pkg::CFG_RST;
            cfg_reg[1] <= pcat_pkg::CFG_RST;
            rdata_reg  <= 32'h0000_0000;
        end else begin
            cfg_reg[0] <= cfg_next[0];
            cfg_reg[1] <= cfg_next[1];
            rdata_reg  <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // ------------------------------------------------------------
    // external wait synchroniser
    // ------------------------------------------------------------
    logic wait_meta_reg;
    logic wait_sync_reg;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_meta_reg <= 1'b0;
            wait_sync_reg <= 1'b0;
        end else begin
            wait_meta_reg <= ~card_wait_n;
            wait_sync_reg <= wait_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // access sequencer
    // ------------------------------------------------------------
    pcat_pkg::pcat_state_t state_reg, state_next;
    logic [7:0]  cnt_reg, cnt_next;
    logic [3:0]  hold_reg, hold_next;
    logic [3:0]  wait_reg, wait_next;
    logic        mask_reg, mask_next;
    logic        io_reg, io_next;
    logic        wr_reg, wr_next;
    logic        done_reg, done_next;
    logic [31:0] sel_cfg;
    logic        start;
    logic        sel_attr;
    logic [7:0]  wait_len;

    // wait cycles of the captured wait field
    assign wait_len = wait_cycles(wait_reg);

    assign sel_cfg  = cfg_reg[acc_area];
    assign start    = acc_req && (state_reg == pcat_pkg::PCAT_IDLE);
    assign sel_attr = acc_a25 ? sel_cfg[pcat_pkg::UPPER_ATTR_BIT]
                              : sel_cfg[pcat_pkg::LOWER_ATTR_BIT];

    // settings are captured when the access starts
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        hold_next  = hold_reg;
        wait_next  = wait_reg;
        mask_next  = mask_reg;
        io_next    = io_reg;
        wr_next    = wr_reg;
        done_next  = 1'b0;
        unique case (state_reg)
            pcat_pkg::PCAT_IDLE: begin
                if (start) begin
                    state_next = pcat_pkg::PCAT_SETUP;
                    cnt_next   = half_ticks(sel_cfg[pcat_pkg::DELAY_LSB +: 4])
                               - 8'h01;
                    hold_next  = sel_cfg[pcat_pkg::HOLD_LSB +: 4];
                    wait_next  = sel_cfg[pcat_pkg::WAIT_LSB +: 4];
                    mask_next  = sel_cfg[pcat_pkg::EXT_MASK_BIT];
                    io_next    = area_card_mode[acc_area] && sel_attr;
                    wr_next    = acc_write;
                end
            end
            pcat_pkg::PCAT_SETUP: begin
                if (cnt_reg == 8'h00) begin
                    state_next = pcat_pkg::PCAT_STROBE;
                    cnt_next   = {wait_len[6:0], 1'b0}
                               - 8'h01;
                end else begin
                    cnt_next = cnt_reg - 8'h01;
                end
            end
            pcat_pkg::PCAT_STROBE: begin
                if (cnt_reg != 8'h00) begin
                    cnt_next = cnt_reg - 8'h01;
                end else if (!mask_reg && wait_sync_reg) begin
                    state_next = pcat_pkg::PCAT_STROBE;
                end else begin
                    state_next = pcat_pkg::PCAT_HOLD;
                    cnt_next   = half_ticks(hold_reg) - 8'h01;
                end
            end
            pcat_pkg::PCAT_HOLD: begin
                if (cnt_reg == 8'h00) begin
                    state_next = pcat_pkg::PCAT_IDLE;
                    done_next  = 1'b1;
                end else begin
                    cnt_next = cnt_reg - 8'h01;
                end
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= pcat_pkg::PCAT_IDLE;
            cnt_reg   <= 8'h00;
            hold_reg  <= 4'h0;
            wait_reg  <= 4'h0;
            mask_reg  <= 1'b0;
            io_reg    <= 1'b0;
            wr_reg    <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            hold_reg  <= hold_next;
            wait_reg  <= wait_next;
            mask_reg  <= mask_next;
            io_reg    <= io_next;
            wr_reg    <= wr_next;
            done_reg  <= done_next;
        end
    end

    // card pins decoded from the state register
    assign acc_busy        = state_reg != pcat_pkg::PCAT_IDLE;
    assign acc_done        = done_reg;
    assign card_addr_valid = state_reg != pcat_pkg::PCAT_IDLE;
    assign card_rd_n       = !(state_reg == pcat_pkg::PCAT_STROBE && !wr_reg);
    assign card_we_n       = !(state_reg == pcat_pkg::PCAT_STROBE && wr_reg);
    assign card_io_sel     = io_reg && acc_busy;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [7:0] len_reg;
    logic [3:0] dly_chk_reg;
    logic       up_attr;
    logic       lo_attr;
    logic       sel_mode;

    assign up_attr  = sel_cfg[pcat_pkg::UPPER_ATTR_BIT];
    assign lo_attr  = sel_cfg[pcat_pkg::LOWER_ATTR_BIT];
    assign sel_mode = area_card_mode[acc_area];

    // cycles spent in the current state
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            len_reg <= 8'h00;
        end else if (state_next != state_reg) begin
            len_reg <= 8'h00;
        end else begin
            len_reg <= len_reg + 8'h01;
        end
    end

    // setup field seen at accept, for the setup length check
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            dly_chk_reg <= 4'h0;
        end else if (start) begin
            dly_chk_reg <= sel_cfg[pcat_pkg::DELAY_LSB +: 4];
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence s_setup;
        state_reg == pcat_pkg::PCAT_SETUP && card_rd_n && card_we_n;
    endsequence
    sequence s_strobe_or_setup;
        state_reg inside {pcat_pkg::PCAT_SETUP, pcat_pkg::PCAT_STROBE};
    endsequence

    rsv_read_zero_a: assert property (
        reg_rd |=> (reg_rdata & ~pcat_pkg::CFG_WR_MASK) == 32'h0)
        else $error("reserved bits read nonzero");
    upper_attr_sel_a: assert property (
        start && acc_a25 && sel_mode |=> card_io_sel == $past(up_attr))
        else $error("upper half space select wrong");
    lower_attr_sel_a: assert property (
        start && !acc_a25 && sel_mode |=> card_io_sel == $past(lo_attr))
        else $error("lower half space select wrong");
    attr_gated_a: assert property (
        start && !sel_mode |=> !card_io_sel)
        else $error("space select outside card mode");
    setup_len_a: assert property (
        state_reg == pcat_pkg::PCAT_SETUP && state_next != state_reg
        |-> len_reg + 8'h01 == half_ticks(dly_chk_reg))
        else $error("setup delay length wrong");
    reset_values_a: assert property (
        !$past(arst_n) |->
            cfg_reg[0][pcat_pkg::WAIT_LSB +: 4] == pcat_pkg::WAIT_RST &&
            cfg_reg[1][pcat_pkg::WAIT_LSB +: 4] == pcat_pkg::WAIT_RST)
        else $error("wait field reset value wrong");
    reset_delay_a: assert property (
        !$past(arst_n) |->
            cfg_reg[0][pcat_pkg::DELAY_LSB +: 4] == pcat_pkg::DELAY_RST &&
            cfg_reg[1][pcat_pkg::DELAY_LSB +: 4] == pcat_pkg::DELAY_RST)
        else $error("setup field reset value wrong");
    strobe_len_a: assert property (
        state_reg == pcat_pkg::PCAT_STROBE && state_next != state_reg &&
        mask_reg |-> len_reg + 8'h01 == {wait_len[6:0], 1'b0})
        else $error("strobe wait length wrong");
    ext_wait_a: assert property (
        state_reg == pcat_pkg::PCAT_STROBE && cnt_reg == 8'h00 &&
        !mask_reg && wait_sync_reg |=> !card_rd_n || !card_we_n)
        else $error("external wait not honoured");
    ext_mask_a: assert property (
        state_reg == pcat_pkg::PCAT_STROBE && cnt_reg == 8'h00 && mask_reg
        |=> state_reg == pcat_pkg::PCAT_HOLD && card_addr_valid)
        else $error("masked wait still stretched strobe");
    hold_len_a: assert property (
        state_reg == pcat_pkg::PCAT_HOLD && state_next != state_reg
        |-> len_reg + 8'h01 == half_ticks(hold_reg) ##1 acc_done)
        else $error("address hold length wrong");
    access_order_a: assert property (
        start |=> s_setup ##1 s_strobe_or_setup)
        else $error("access sequence out of order");
endmodule

// ===== verilog/pcat_pkg.sv
package pcat_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0]  AREA5_CFG_OFS = 8'h00;
    localparam logic [7:0]  AREA6_CFG_OFS = 8'h04;
    localparam logic [31:0] CFG_RST       = 32'h0000_0500;
    localparam logic [31:0] CFG_WR_MASK   = 32'h0030_7fcf;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int UPPER_ATTR_BIT = 21;
    localparam int LOWER_ATTR_BIT = 20;
    localparam int DELAY_LSB      = 11;
    localparam int WAIT_LSB       = 7;
    localparam int EXT_MASK_BIT   = 6;
    localparam int HOLD_LSB       = 0;
    localparam logic [3:0] WAIT_RST  = 4'ha;
    localparam logic [3:0] DELAY_RST = 4'h0;
    // ------------------------------------------------------------
    // timing: one bus cycle is two ref_clk periods (half cycle = 1)
    // ------------------------------------------------------------
    localparam logic [7:0] HALF_TICKS = 8'h01;
    // ------------------------------------------------------------
    // access sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PCAT_IDLE   = 2'b00,
        PCAT_SETUP  = 2'b01,
        PCAT_STROBE = 2'b10,
        PCAT_HOLD   = 2'b11
    } pcat_state_t;
endpackage
